/* verilog/meter_counter_peak_host_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - duty bit low measures frequency, high measures duty cycle.
// - time-base and signal counters, both readable, give the ratio.
// - rising edge of the counter restart bit starts a measurement run.
// - a run ends after about 0.2 s and signals the host.
// - end of counting sets the counter event status bit.
// - peak logic takes only the fast result into two comparators.
// - peak clear low forces positive to most negative, negative to most positive.
// - positive peak loads a larger fast result, otherwise holds.
// - negative peak loads a smaller fast result, otherwise holds.
// - port has select, write, read, latch strobe, nibble bus, request.
// - control registers are eight bits, written and read back; general control b bits 6:4 read the analog status.
// - chip reset clears every control register to zero.
// - controls at 00 to 08; 09 holds status high, enable low.
// - general control a bit 2 selects duty, bit 1 restarts on its rising edge.
// - general control a bit 0 is the active-low peak clear.
// - setup bits 5:4 offset cancel mode, 3:0 two filter lengths.
// - each byte moves as two nibbles, upper nibble first.
// - every address latch strobe returns the sequencer to the upper nibble.
// - an enabled status bit pulls the request low until a read of 09 or of its result register clears it.
// - status bits flag counter, peak, fast, slow; enables gate only request.
// - reading signal count clears counter status; time-base read does not.
module meter_counter_peak_host_port
	import meter_port_pkg::*;
#(
	parameter int unsigned gate_cycles = GATE_CYCLES
)
(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// host port pins
	input  wire logic             cs_n,
	input  wire logic             wr_n,
	input  wire logic             rd_n,
	input  wire logic             ale,
	input  wire logic [3:0]       muxed_bus_in,
	output logic      [3:0]       muxed_bus_out,
	output logic                  muxed_bus_oe_n,
	output logic                  event_request_n,
	// measurement inputs
	input  wire logic             reference_time_pulse,
	input  wire logic             measured_signal,
	input  wire logic [2:0]       analog_status,
	input  wire logic [15:0]      fast_conversion_result,
	input  wire logic             fast_result_valid,
	input  wire logic [23:0]      slow_conversion_result,
	input  wire logic             slow_result_valid,
	// control outputs
	output control_bank_type      control_bank,
	output logic      [1:0]       offset_cancel_mode,
	output logic      [1:0]       fast_filter_length,
	output logic      [1:0]       slow_filter_length
);

	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	host_pins_type     pins;
	logic              ref_s;
	logic              sig_s;
	logic [2:0]        status_s;
	logic              ref_prev;
	logic              sig_prev;
	logic              ref_edge;
	logic              sig_edge;
	logic              wr_prev;
	logic              rd_prev;
	logic              wr_rise;
	logic              rd_rise;
	logic [7:0]        ctrl_reg [CTRL_COUNT];
	logic [3:0]        event_status;
	logic [3:0]        event_enable;
	logic [3:0]        next_event_status;
	logic [3:0]        status_clear;
	logic [3:0]        bus_addr;
	logic [2:0]        nibble_index;
	logic [3:0]        upper_hold;
	logic [23:0]       snapshot;
	logic [23:0]       read_value;
	logic              read_done;
	logic              duty_mode_select;
	logic              counter_restart_n;
	logic              restart_prev;
	logic              restart_rise;
	logic              peak_clear_n;
	counter_state_type state;
	logic [24:0]       gate_cnt;
	logic [23:0]       timebase_count;
	logic [23:0]       signal_count;
	logic              count_done;
	logic [15:0]       positive_peak_hold;
	logic [15:0]       negative_peak_hold;
	logic              peak_updated;

	// nibble length of each address
	function automatic logic [2:0] nibble_count(input logic [3:0] addr);
		if (addr <= ADDR_EVENT) begin
			nibble_count = NIBBLES_BYTE;
		end else if (addr == ADDR_TIMEBASE || addr == ADDR_SIGCOUNT ||
			addr == ADDR_SLOW) begin
			nibble_count = NIBBLES_WIDE;
		end else begin
			nibble_count = NIBBLES_HALF;
		end
	endfunction

	// two-flop synchroniser for host pins, reference, signal and analog status
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= SYNC_RESET;
			sync_b <= SYNC_RESET;
		end else begin
			sync_a <= {cs_n, wr_n, rd_n, ale, muxed_bus_in,
				reference_time_pulse, measured_signal, analog_status};
			sync_b <= sync_a;
		end
	end

	assign pins     = host_pins_type'(sync_b[12:5]);
	assign ref_s    = sync_b[4];
	assign sig_s    = sync_b[3];
	assign status_s = sync_b[2:0];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_prev <= 1'b0;
			sig_prev <= 1'b0;
			wr_prev  <= 1'b1;
			rd_prev  <= 1'b1;
		end else begin
			ref_prev <= ref_s;
			sig_prev <= sig_s;
			wr_prev  <= pins.wr_n;
			rd_prev  <= pins.rd_n;
		end
	end

	assign ref_edge = ref_s && !ref_prev;
	assign sig_edge = sig_s && !sig_prev;
	assign wr_rise  = pins.wr_n && !wr_prev && !pins.cs_n;
	assign rd_rise  = pins.rd_n && !rd_prev && !pins.cs_n;
	assign read_done = rd_rise &&
		(nibble_index == nibble_count(bus_addr) - 3'h1);

	// address latch and nibble sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_addr     <= ADDR_RANGE_MODE;
			nibble_index <= 3'h0;
		end else if (pins.ale) begin
			bus_addr     <= pins.ad;
			nibble_index <= 3'h0;
		end else if (wr_rise || rd_rise) begin
			nibble_index <= nibble_index + 3'h1;
		end
	end

	// control register writes, upper nibble first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upper_hold   <= 4'h0;
			event_enable <= 4'h0;
			for (int i = 0; i < CTRL_COUNT; i++) begin
				ctrl_reg[i] <= CTRL_RESET;
			end
		end else if (wr_rise && nibble_index == 3'h0) begin
			upper_hold <= pins.ad;
		end else if (wr_rise && nibble_index == 3'h1) begin
			if (bus_addr == ADDR_EVENT) begin
				event_enable <= pins.ad;
			end else if (bus_addr < ADDR_EVENT) begin
				ctrl_reg[bus_addr] <= {upper_hold, pins.ad};
			end
		end
	end

	// read mux, narrow values left-justified for upper-first reads
	always_comb begin
		read_value = 24'h000000;
		unique case (bus_addr)
			ADDR_GENERAL_B: read_value[23:16] = {ctrl_reg[8][7],
				status_s, ctrl_reg[8][3:0]};
			ADDR_EVENT:     read_value[23:16] = {event_status,
				event_enable};
			ADDR_TIMEBASE:  read_value = timebase_count;
			ADDR_SIGCOUNT:  read_value = signal_count;
			ADDR_POS_PEAK:  read_value[23:8] = positive_peak_hold;
			ADDR_NEG_PEAK:  read_value[23:8] = negative_peak_hold;
			ADDR_FAST:      read_value[23:8] = fast_conversion_result;
			ADDR_SLOW:      read_value = slow_conversion_result;
			default:        read_value[23:16] = ctrl_reg[bus_addr];
		endcase
	end

	// value captured while the address strobe is high, frozen after it falls
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			snapshot <= 24'h000000;
		end else if (pins.ale) begin
			snapshot <= read_value;
		end
	end

	// bus drive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			muxed_bus_out  <= 4'h0;
			muxed_bus_oe_n <= 1'b1;
		end else begin
			muxed_bus_out  <= snapshot[5'd23 - {nibble_index, 2'b00} -: 4];
			muxed_bus_oe_n <= pins.cs_n || pins.rd_n || pins.ale;
		end
	end

	// status clears by completed reads
	always_comb begin
		status_clear = 4'h0;
		if (read_done) begin
			unique case (bus_addr)
				ADDR_EVENT:    status_clear = snapshot[23:20];
				ADDR_SIGCOUNT: status_clear[EVT_COUNTER] = 1'b1;
				ADDR_POS_PEAK,
				ADDR_NEG_PEAK: status_clear[EVT_PEAK] = 1'b1;
				ADDR_FAST:     status_clear[EVT_FAST] = 1'b1;
				ADDR_SLOW:     status_clear[EVT_SLOW] = 1'b1;
				default:       status_clear = 4'h0;
			endcase
		end
	end

	// set wins over clear; enables never touch status
	assign next_event_status = {count_done, peak_updated,
		fast_result_valid, slow_result_valid} |
		(event_status & ~status_clear);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_status    <= 4'h0;
			event_request_n <= 1'b1;
		end else begin
			event_status    <= next_event_status;
			event_request_n <= ~|(event_status & event_enable);
		end
	end

	// control fields
	assign duty_mode_select   = ctrl_reg[7][DUTY_MODE_BIT];
	assign counter_restart_n  = ctrl_reg[7][RESTART_N_BIT];
	assign peak_clear_n       = ctrl_reg[7][PEAK_CLEAR_N_BIT];
	assign offset_cancel_mode = ctrl_reg[6][OFFSET_CANCEL_LSB +: 2];
	assign fast_filter_length = ctrl_reg[6][FAST_FILTER_LSB +: 2];
	assign slow_filter_length = ctrl_reg[6][SLOW_FILTER_LSB +: 2];
	assign control_bank = {ctrl_reg[0], ctrl_reg[1], ctrl_reg[2],
		ctrl_reg[3], ctrl_reg[4], ctrl_reg[5], ctrl_reg[6], ctrl_reg[7],
		ctrl_reg[8]};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			restart_prev <= 1'b0;
		end else begin
			restart_prev <= counter_restart_n;
		end
	end

	assign restart_rise = counter_restart_n && !restart_prev;
	assign count_done   = (state == CNT_DONE);

	// counter run sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= CNT_IDLE;
			gate_cnt <= 25'h0000000;
		end else if (restart_rise) begin
			state    <= CNT_RUN;
			gate_cnt <= 25'h0000000;
		end else begin
			unique case (state)
				CNT_IDLE: state <= CNT_IDLE;
				CNT_RUN: begin
					gate_cnt <= gate_cnt + 25'h0000001;
					if (gate_cnt == 25'(gate_cycles - 1)) begin
						state <= CNT_DONE;
					end
				end
				CNT_DONE: state <= CNT_IDLE;
				default:  state <= CNT_IDLE;
			endcase
		end
	end

	// counts, held after the run
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timebase_count <= 24'h000000;
			signal_count   <= 24'h000000;
		end else if (restart_rise) begin
			timebase_count <= 24'h000000;
			signal_count   <= 24'h000000;
		end else if (state == CNT_RUN) begin
			if (ref_edge) begin
				timebase_count <= timebase_count + 24'h000001;
			end
			if (duty_mode_select ? (ref_edge && sig_s) : sig_edge) begin
				signal_count <= signal_count + 24'h000001;
			end
		end
	end

	peak_hold_unit u_peak (
		.core_clk               (core_clk),
		.rst_n                  (rst_n),
		.peak_clear_n           (peak_clear_n),
		.sample_valid           (fast_result_valid),
		.fast_conversion_result (fast_conversion_result),
		.positive_peak_hold     (positive_peak_hold),
		.negative_peak_hold     (negative_peak_hold),
		.peak_updated           (peak_updated)
	);

	a_restart_starts_run: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		restart_rise |=> state == CNT_RUN && gate_cnt == 25'h0000000)
		else $error("restart did not start a run");

	a_done_sets_status: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		count_done |=> event_status[EVT_COUNTER] ##1 !count_done)
		else $error("counter completion not flagged");

	a_counts_held: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		state != CNT_RUN && !restart_rise
		|=> $stable(timebase_count) && $stable(signal_count))
		else $error("counter result changed outside a run");

	a_duty_counting: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		state == CNT_RUN && !restart_rise && duty_mode_select &&
			ref_edge && sig_s
		|=> signal_count == $past(signal_count) + 24'h000001)
		else $error("duty count missed a high sample");

	a_ale_upper_nibble: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		pins.ale |=> nibble_index == 3'h0)
		else $error("sequencer not back at the upper nibble");

	a_request_follows: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		|(event_status & event_enable) |=> !event_request_n)
		else $error("enabled event did not pull the request low");

	a_timebase_read_keeps: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		read_done && bus_addr == ADDR_TIMEBASE && !count_done
		|=> event_status[EVT_COUNTER] == $past(event_status[EVT_COUNTER]))
		else $error("time-base read disturbed counter status");

	a_slow_status_set: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		slow_result_valid |=> event_status[EVT_SLOW])
		else $error("slow result did not set its status");

endmodule

/* verilog/meter_port_pkg.sv */
package meter_port_pkg;

	// register addresses on the nibble bus
	localparam logic [3:0] ADDR_RANGE_MODE  = 4'h0;
	localparam logic [3:0] ADDR_SIGNAL_PATH = 4'h1;
	localparam logic [3:0] ADDR_REF_PATH    = 4'h2;
	localparam logic [3:0] ADDR_COMP_PATH   = 4'h3;
	localparam logic [3:0] ADDR_AMP_FUNC    = 4'h4;
	localparam logic [3:0] ADDR_CONV_GAIN   = 4'h5;
	localparam logic [3:0] ADDR_CONV_SETUP  = 4'h6;
	localparam logic [3:0] ADDR_GENERAL_A   = 4'h7;
	localparam logic [3:0] ADDR_GENERAL_B   = 4'h8;
	localparam logic [3:0] ADDR_EVENT       = 4'h9;
	localparam logic [3:0] ADDR_TIMEBASE    = 4'hA;
	localparam logic [3:0] ADDR_SIGCOUNT    = 4'hB;
	localparam logic [3:0] ADDR_POS_PEAK    = 4'hC;
	localparam logic [3:0] ADDR_NEG_PEAK    = 4'hD;
	localparam logic [3:0] ADDR_FAST        = 4'hE;
	localparam logic [3:0] ADDR_SLOW        = 4'hF;
	localparam int         CTRL_COUNT       = 9;
	localparam logic [7:0] CTRL_RESET       = 8'h00;

	// field positions
	localparam int PEAK_CLEAR_N_BIT  = 0;
	localparam int RESTART_N_BIT     = 1;
	localparam int DUTY_MODE_BIT     = 2;
	localparam int OFFSET_CANCEL_LSB = 4;
	localparam int FAST_FILTER_LSB   = 2;
	localparam int SLOW_FILTER_LSB   = 0;
	localparam int ANALOG_STATUS_LSB = 4;
	localparam int EVT_SLOW          = 0;
	localparam int EVT_FAST          = 1;
	localparam int EVT_PEAK          = 2;
	localparam int EVT_COUNTER       = 3;

	// nibbles per register read
	localparam logic [2:0] NIBBLES_BYTE = 3'h2;
	localparam logic [2:0] NIBBLES_HALF = 3'h4;
	localparam logic [2:0] NIBBLES_WIDE = 3'h6;

	// peak extremes, two's complement
	localparam logic [15:0] PEAK_MOST_NEG = 16'h8000;
	localparam logic [15:0] PEAK_MOST_POS = 16'h7FFF;

	// counter gate time
	localparam int GATE_TIME_MS  = 200;
	localparam int CLK_PERIOD_NS = 10;
	localparam int GATE_CYCLES   = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// synchroniser: {cs_n, wr_n, rd_n, ale, ad[3:0], ref, sig, status[2:0]}
	localparam int          SYNC_W     = 13;
	localparam logic [12:0] SYNC_RESET = 13'h1C00;

	typedef struct packed {
		logic       cs_n;
		logic       wr_n;
		logic       rd_n;
		logic       ale;
		logic [3:0] ad;
	} host_pins_type;

	typedef struct packed {
		logic [7:0] range_mode_select;
		logic [7:0] signal_input_path;
		logic [7:0] reference_input_path;
		logic [7:0] comparator_path;
		logic [7:0] amplifier_function_ctrl;
		logic [7:0] converter_gain_ctrl;
		logic [7:0] converter_setup;
		logic [7:0] general_ctrl_a;
		logic [7:0] general_ctrl_b;
	} control_bank_type;

	typedef enum logic [2:0] {
		CNT_IDLE = 3'b001,
		CNT_RUN  = 3'b010,
		CNT_DONE = 3'b100
	} counter_state_type;

endpackage

/* verilog/peak_hold_unit.sv */
`timescale 1ns/1ps
module peak_hold_unit
	import meter_port_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// control and sample
	input  wire logic        peak_clear_n,
	input  wire logic        sample_valid,
	input  wire logic [15:0] fast_conversion_result,
	// held peaks
	output logic      [15:0] positive_peak_hold,
	output logic      [15:0] negative_peak_hold,
	output logic             peak_updated
);

	logic pos_load;
	logic neg_load;

	// signed compare against the stored extremes
	assign pos_load = sample_valid && ($signed(fast_conversion_result) >
		$signed(positive_peak_hold));
	assign neg_load = sample_valid && ($signed(fast_conversion_result) <
		$signed(negative_peak_hold));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			positive_peak_hold <= PEAK_MOST_NEG;
		end else if (!peak_clear_n) begin
			positive_peak_hold <= PEAK_MOST_NEG;
		end else if (pos_load) begin
			positive_peak_hold <= fast_conversion_result;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			negative_peak_hold <= PEAK_MOST_POS;
		end else if (!peak_clear_n) begin
			negative_peak_hold <= PEAK_MOST_POS;
		end else if (neg_load) begin
			negative_peak_hold <= fast_conversion_result;
		end
	end

	// new peak seen while tracking
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_updated <= 1'b0;
		end else begin
			peak_updated <= peak_clear_n && (pos_load || neg_load);
		end
	end

	a_peak_clear_forces: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!peak_clear_n |=> (positive_peak_hold == PEAK_MOST_NEG) &&
			(negative_peak_hold == PEAK_MOST_POS))
		else $error("peak clear did not force the extremes");

	a_pos_peak_load: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		peak_clear_n && sample_valid && ($signed(fast_conversion_result) >
			$signed(positive_peak_hold))
		|=> positive_peak_hold == $past(fast_conversion_result))
		else $error("positive peak missed a larger sample");

	a_neg_peak_keep: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		peak_clear_n && !($signed(fast_conversion_result) <
			$signed(negative_peak_hold) && sample_valid)
		|=> $stable(negative_peak_hold))
		else $error("negative peak changed without a smaller sample");

endmodule

/* sim/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
	// clock
	input  wire logic       core_clk,
	// device side of the nibble bus
	input  wire logic [3:0] muxed_bus_out,
	input  wire logic       muxed_bus_oe_n,
	// host pins
	output logic            cs_n,
	output logic            wr_n,
	output logic            rd_n,
	output logic            ale,
	output logic      [3:0] muxed_bus_in
);
	logic       host_oe;
	logic [3:0] host_ad;
	logic [3:0] last_ad;

	initial begin
		cs_n    = 1'b1;
		wr_n    = 1'b1;
		rd_n    = 1'b1;
		ale     = 1'b0;
		host_oe = 1'b0;
		host_ad = 4'h0;
		last_ad = 4'h0;
	end

	// a released bus shows a changing pattern, not its last level
	always @(posedge core_clk)
		last_ad <= muxed_bus_in;

	always_comb begin
		if (!muxed_bus_oe_n)
			muxed_bus_in = muxed_bus_out;
		else if (host_oe)
			muxed_bus_in = host_ad;
		else
			muxed_bus_in = ~last_ad;
	end

	task automatic latch(input logic [3:0] addr);
		@(posedge core_clk);
		ale     <= 1'b1;
		host_oe <= 1'b1;
		host_ad <= addr;
		repeat (4) @(posedge core_clk);
		ale <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic wr(input logic [3:0] addr, input logic [7:0] data,
			input int n);
		latch(addr);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			host_ad <= (i == 0) ? data[7:4] : data[3:0];
			wr_n    <= 1'b0;
			repeat (4) @(posedge core_clk);
			wr_n <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
		cs_n    <= 1'b1;
		host_oe <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic rd(input logic [3:0] addr, input int n,
			output logic [23:0] val);
		latch(addr);
		host_oe <= 1'b0;
		cs_n    <= 1'b0;
		val = '0;
		for (int i = 0; i < n; i++) begin
			rd_n <= 1'b0;
			repeat (6) @(posedge core_clk);
			@(negedge core_clk);
			val = {val[19:0], muxed_bus_in};
			@(posedge core_clk);
			rd_n <= 1'b1;
			repeat (4) @(posedge core_clk);
		end
		cs_n <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask
endmodule

/* sim/meter_counter_peak_host_port_tb.sv */
`timescale 1ns/1ps
module meter_counter_peak_host_port_tb;
	import meter_port_pkg::*;
	localparam int unsigned gate_len = 200;

	logic             core_clk;
	logic             rst_n;
	logic             cs_n;
	logic             wr_n;
	logic             rd_n;
	logic             ale;
	logic      [3:0]  muxed_bus_in;
	logic      [3:0]  muxed_bus_out;
	logic             muxed_bus_oe_n;
	logic             event_request_n;
	logic             reference_time_pulse;
	logic             measured_signal;
	logic      [2:0]  analog_status;
	logic      [15:0] fast_conversion_result;
	logic             fast_result_valid;
	logic      [23:0] slow_conversion_result;
	logic             slow_result_valid;
	control_bank_type control_bank;
	logic      [1:0]  offset_cancel_mode;
	logic      [1:0]  fast_filter_length;
	logic      [1:0]  slow_filter_length;
	logic      [7:0]  src_cnt;
	logic      [7:0]  wv [9];
	logic      [23:0] v;
	logic      [23:0] tb_v;
	logic      [23:0] sg_v;
	int               num_errors;
	int               checked;

	meter_counter_peak_host_port #(.gate_cycles(gate_len)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .ale(ale), .muxed_bus_in(muxed_bus_in),
		.muxed_bus_out(muxed_bus_out), .muxed_bus_oe_n(muxed_bus_oe_n),
		.event_request_n(event_request_n),
		.reference_time_pulse(reference_time_pulse),
		.measured_signal(measured_signal), .analog_status(analog_status),
		.fast_conversion_result(fast_conversion_result),
		.fast_result_valid(fast_result_valid),
		.slow_conversion_result(slow_conversion_result),
		.slow_result_valid(slow_result_valid), .control_bank(control_bank),
		.offset_cancel_mode(offset_cancel_mode),
		.fast_filter_length(fast_filter_length),
		.slow_filter_length(slow_filter_length));

	host_bus_model host (
		.core_clk(core_clk), .muxed_bus_out(muxed_bus_out),
		.muxed_bus_oe_n(muxed_bus_oe_n), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .ale(ale), .muxed_bus_in(muxed_bus_in));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// reference every 8 cycles, signal every 32 cycles
	always @(posedge core_clk) begin
		src_cnt              <= src_cnt + 8'h01;
		reference_time_pulse <= src_cnt[2];
		measured_signal      <= src_cnt[4];
	end

	task automatic check_value(input logic [23:0] seen,
			input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input int n,
			input logic [23:0] exp);
		logic [23:0] r;
		host.rd(a, n, r);
		check_value(r, exp);
	endtask

	task automatic fast_sample(input logic [15:0] s);
		@(posedge core_clk);
		fast_conversion_result <= s;
		fast_result_valid      <= 1'b1;
		@(posedge core_clk);
		fast_result_valid <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		rst_n                  = 1'b0;
		src_cnt                = 8'h00;
		reference_time_pulse   = 1'b0;
		measured_signal        = 1'b0;
		analog_status          = 3'h0;
		fast_conversion_result = 16'h0000;
		fast_result_valid      = 1'b0;
		slow_conversion_result = 24'h000000;
		slow_result_valid      = 1'b0;
		num_errors             = 0;
		checked                = 0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);

		// reset values
		check_value(24'(control_bank), 24'h0);
		check_value(24'(event_request_n), 24'h1);
		for (int a = 0; a < 10; a++)
			rd_chk(4'(a), 2, 24'h0);
		$display("test reset done");

		// write all controls, then read back
		analog_status <= 3'h5;
		for (int a = 0; a < 9; a++) begin
			wv[a] = 8'h5A + 8'(a * 29);
			host.wr(4'(a), wv[a], 2);
		end
		for (int a = 0; a < 8; a++)
			rd_chk(4'(a), 2, 24'(wv[a]));
		rd_chk(ADDR_GENERAL_B, 2, 24'((wv[8] & 8'h8F) | 8'h50));
		for (int a = 0; a < 9; a++)
			check_value(24'(control_bank[(8 - a) * 8 +: 8]), 24'(wv[a]));
		check_value(24'(offset_cancel_mode), 24'(wv[6][5:4]));
		check_value(24'(fast_filter_length), 24'(wv[6][3:2]));
		check_value(24'(slow_filter_length), 24'(wv[6][1:0]));
		host.wr(ADDR_EVENT, 8'hF0, 2);
		rd_chk(ADDR_EVENT, 2, 24'h00);
		host.wr(ADDR_RANGE_MODE, 8'hC3, 1);
		host.wr(ADDR_RANGE_MODE, 8'h3C, 2);
		host.rd(ADDR_RANGE_MODE, 1, v);
		rd_chk(ADDR_RANGE_MODE, 2, 24'h3C);
		$display("test registers done");

		// peak hold: clear, release, sample, read
		host.wr(ADDR_GENERAL_A, 8'h00, 2);
		fast_sample(16'h1234);
		rd_chk(ADDR_POS_PEAK, 4, 24'h8000);
		rd_chk(ADDR_NEG_PEAK, 4, 24'h7FFF);
		host.wr(ADDR_GENERAL_A, 8'h01, 2);
		fast_sample(16'h0100);
		fast_sample(16'hFF00);
		fast_sample(16'h0050);
		check_value(24'(event_request_n), 24'h1);
		host.wr(ADDR_EVENT, 8'h04, 2);
		check_value(24'(event_request_n), 24'h0);
		rd_chk(ADDR_EVENT, 2, 24'h64);
		check_value(24'(event_request_n), 24'h1);
		@(posedge core_clk);
		slow_conversion_result <= 24'h9ABCDE;
		slow_result_valid      <= 1'b1;
		@(posedge core_clk);
		slow_result_valid <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd_chk(ADDR_EVENT, 2, 24'h14);
		fast_sample(16'h0080);
		fast_sample(16'hFE00);
		rd_chk(ADDR_POS_PEAK, 4, 24'h0100);
		rd_chk(ADDR_NEG_PEAK, 4, 24'hFE00);
		rd_chk(ADDR_FAST, 4, 24'hFE00);
		rd_chk(ADDR_SLOW, 6, 24'h9ABCDE);
		$display("test peak done");

		// counter: first run discarded, then frequency and duty runs
		host.rd(ADDR_EVENT, 2, v);
		host.wr(ADDR_EVENT, 8'h08, 2);
		for (int run = 0; run < 3; run++) begin
			host.wr(ADDR_GENERAL_A, (run == 2) ? 8'h05 : 8'h01, 2);
			host.wr(ADDR_GENERAL_A, (run == 2) ? 8'h07 : 8'h03, 2);
			check_value(24'(event_request_n), 24'h1);
			for (int i = 0; i < 600 && event_request_n !== 1'b0; i++)
				@(posedge core_clk);
			if (event_request_n !== 1'b0) begin
				check_value(24'(event_request_n), 24'h0);
				end_of_test();
			end
			check_value(24'(event_request_n), 24'h0);
			host.rd(ADDR_TIMEBASE, 6, tb_v);
			check_value(24'(event_request_n), 24'h0);
			host.rd(ADDR_SIGCOUNT, 6, sg_v);
			check_value(24'(event_request_n), 24'h1);
			if (run > 0) begin
				check_value(24'(tb_v >= 24 && tb_v <= 26), 24'h1);
				if (run == 1)
					check_value(24'(sg_v >= 5 && sg_v <= 7), 24'h1);
				else
					check_value(24'(sg_v >= 11 && sg_v <= 14), 24'h1);
				repeat (300) @(posedge core_clk);
				rd_chk(ADDR_SIGCOUNT, 6, sg_v);
				rd_chk(ADDR_TIMEBASE, 6, tb_v);
			end
		end
		$display("test counter done");
		end_of_test();
	end
endmodule
